// >>> fdo_regs.svh
/*
 * Register offsets, field positions, reset values and limits of the
 * frequency-detect output selector.
 * Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
 */
`ifndef FDO_REGS_SVH
`define FDO_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FDO_LEVEL_OFS      8'h00
`define FDO_BANDWIDTH_OFS  8'h04
`define FDO_MAXFREQ_OFS    8'h08
`define FDO_SELECT_OFS     8'h0C
`define FDO_MASK_OFS       8'h10
`define FDO_STATUS_OFS     8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FDO_SEL_OC_LSB     0
`define FDO_SEL_RELAY_LSB  8
`define FDO_STAT_OC_BIT    24
`define FDO_STAT_RELAY_BIT 25

// ----------------------------------------------------------------
// reset values and limits, frequencies in units of 0.01 Hz
// ----------------------------------------------------------------
`define FDO_LEVEL_RESET    16'h0BB8
`define FDO_BW_RESET       16'h03E8
`define FDO_MAXFREQ_RESET  16'h1770
`define FDO_FREQ_LIMIT     16'h9C40
`define FDO_SEL_OC_RESET   5'h0C
`define FDO_SEL_RLY_RESET  5'h11
`define FDO_SEL_MAX        5'h11
`define FDO_MASK_RESET     3'h2

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define FDO_RESP_OKAY      2'h0
`define FDO_RESP_SLVERR    2'h2
`define FDO_RESP_DECERR    2'h3

`endif

// >>> fdo_pkg.sv
/*
 * Types shared by the frequency-detect output selector files.
 * Assumes nothing beyond a SystemVerilog package scope.
 */
`default_nettype none

package fdo_pkg;

	typedef logic [15:0] freq_t;
	typedef logic [4:0]  sel_t;
	typedef logic [17:0] cond_t;

	// drive state flags supplied by the rest of the drive
	typedef struct packed {
		logic accelerating;
		logic decelerating;
		logic overload_warn;
		logic inverter_overload;
		logic motor_stall;
		logic overvoltage_trip;
		logic undervoltage_trip;
		logic heatsink_overtemp_trip;
		logic command_lost;
		logic run_command;
		logic output_active;
		logic stopped;
		logic constant_speed;
		logic speed_searching;
		logic waiting_run_command;
		logic other_trip;
		logic restart_retrying;
	} drive_status_s;

endpackage

`default_nettype wire

// >>> freq_compare.sv
/*
 * Frequency detection comparisons against level and bandwidth.
 * Assumes all frequencies share one unsigned 0.01 Hz format.
 */
`default_nettype none

module freq_compare
	import fdo_pkg::*;
(
	// clock and reset
	input  wire logic  aclk,
	input  wire logic  aresetn,
	// frequencies
	input  wire freq_t cmd_freq,
	input  wire freq_t run_freq,
	input  wire freq_t level,
	input  wire freq_t bandwidth,
	// ramp direction
	input  wire logic  accelerating,
	input  wire logic  decelerating,
	// conditions
	output logic       freq_match_command,
	output logic       freq_match_level_and_command,
	output logic       freq_within_level_band,
	output logic       freq_above_level_hyst
);

	wire freq_t half_bw   = bandwidth >> 1;
	wire freq_t cmd_diff  = (cmd_freq > run_freq) ? cmd_freq - run_freq : run_freq - cmd_freq;
	wire freq_t lvl_diff  = (level > run_freq) ? level - run_freq : run_freq - level;
	// a band reaching below zero makes the lower threshold always met
	wire logic  below_thr = (level < half_bw) || (run_freq > level - half_bw);
	wire logic  at_level  = run_freq >= level;
	logic       hyst_hold;

	assign freq_match_command           = cmd_diff <= half_bw;
	assign freq_match_level_and_command = (cmd_freq == level) && freq_match_command;
	assign freq_within_level_band       = lvl_diff <= half_bw;
	assign freq_above_level_hyst        = accelerating ? at_level :
	                                      decelerating ? below_thr : hyst_hold;

	// at constant speed the last ramp decision holds
	always_ff @(posedge aclk) begin
		if (!aresetn)
			hyst_hold <= 1'b0;
		else
			hyst_hold <= freq_above_level_hyst;
	end

endmodule

`default_nettype wire

// >>> status_mux.sv
/*
 * One status output: picks a condition code and registers it.
 * Assumes the selector only ever holds codes 0 through 17.
 */
`include "fdo_regs.svh"
`default_nettype none

module status_mux
	import fdo_pkg::*;
(
	// clock and reset
	input  wire logic  aclk,
	input  wire logic  aresetn,
	// selection
	input  wire cond_t cond,
	input  wire sel_t  sel,
	// output
	output logic       status_out
);

	wire logic picked = (sel <= `FDO_SEL_MAX) ? cond[sel] : 1'b0;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			status_out <= 1'b0;
		else
			status_out <= picked;
	end

endmodule

`default_nettype wire

// >>> freq_detect_output_select.sv
/*
 * Status output selector of a motor drive: frequency detection,
 * drive state and fault conditions routed to the open-collector and
 * relay outputs, with settings held in AXI4-Lite registers.
 * Assumes drive flags and frequencies are synchronous to aclk.
 */
// Chosen here: the AXI4-Lite slave port and the address map.
// Contract
// - code 0: command minus output within half band
// - code 1: command equals level and code 0
// - code 2: level minus running within half band
// - code 3: level crossing with deceleration hysteresis
// - code 4: inverse of code 3
// - level, bandwidth 0 to 400 Hz, not above maximum when written
// - code 8: over-voltage trip
// - code 9: under-voltage trip
// - code 10: heatsink over-temperature trip
// - code 11: frequency command lost
// - code 12: run command and output active
// - code 13 stopped, code 14 constant speed
// - code 16: waiting for run command
// - code 17: fault mask drives output
// - mask bits: under-voltage, other trip, retries
// - each output has its own selector
`include "fdo_regs.svh"
`default_nettype none

module freq_detect_output_select
	import fdo_pkg::*;
#(
	parameter int ADDR_W = 8
)(
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// axi4-lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// axi4-lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// drive state
	input  wire freq_t             cmd_freq,
	input  wire freq_t             run_freq,
	input  wire drive_status_s     drive_status,
	// status outputs
	output logic                   open_collector_status_out,
	output logic                   relay_contact_status_out
);

	// ----------------------------------------------------------------
	// settings
	// ----------------------------------------------------------------
	freq_t    detect_level_setting;
	freq_t    detect_bandwidth_setting;
	freq_t    maximum_frequency_limit;
	sel_t     transistor_output_selector;
	sel_t     relay_output_selector;
	logic [2:0] fault_indication_mask;

	// ----------------------------------------------------------------
	// conditions
	// ----------------------------------------------------------------
	logic  freq_match_command;
	logic  freq_match_level_and_command;
	logic  freq_within_level_band;
	logic  freq_above_level_hyst;
	wire logic freq_above_level_hyst_inverted = ~freq_above_level_hyst;
	wire logic fault_indication =
		(fault_indication_mask[0] & drive_status.undervoltage_trip) |
		(fault_indication_mask[1] & drive_status.other_trip) |
		(fault_indication_mask[2] & drive_status.restart_retrying);
	wire logic run_and_output = drive_status.run_command & drive_status.output_active;
	wire cond_t cond = {
		fault_indication,
		drive_status.waiting_run_command,
		drive_status.speed_searching,
		drive_status.constant_speed,
		drive_status.stopped,
		run_and_output,
		drive_status.command_lost,
		drive_status.heatsink_overtemp_trip,
		drive_status.undervoltage_trip,
		drive_status.overvoltage_trip,
		drive_status.motor_stall,
		drive_status.inverter_overload,
		drive_status.overload_warn,
		freq_above_level_hyst_inverted,
		freq_above_level_hyst,
		freq_within_level_band,
		freq_match_level_and_command,
		freq_match_command
	};

	freq_compare u_compare (
		.aclk                         (aclk),
		.aresetn                      (aresetn),
		.cmd_freq                     (cmd_freq),
		.run_freq                     (run_freq),
		.level                        (detect_level_setting),
		.bandwidth                    (detect_bandwidth_setting),
		.accelerating                 (drive_status.accelerating),
		.decelerating                 (drive_status.decelerating),
		.freq_match_command           (freq_match_command),
		.freq_match_level_and_command (freq_match_level_and_command),
		.freq_within_level_band       (freq_within_level_band),
		.freq_above_level_hyst        (freq_above_level_hyst)
	);

	status_mux u_oc_mux (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.cond       (cond),
		.sel        (transistor_output_selector),
		.status_out (open_collector_status_out)
	);

	status_mux u_relay_mux (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.cond       (cond),
		.sel        (relay_output_selector),
		.status_out (relay_contact_status_out)
	);

	// ----------------------------------------------------------------
	// write channel capture
	// ----------------------------------------------------------------
	logic              aw_held;
	logic              w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;

	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held & ~s_axi_bvalid;

	wire logic aw_take = s_axi_awvalid & s_axi_awready;
	wire logic w_take  = s_axi_wvalid & s_axi_wready;
	wire logic wr_fire = aw_held & w_held & ~s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	wire logic [7:0] wa = 8'(aw_addr);
	wire logic [7:0] ra = 8'(s_axi_araddr);
	wire logic [31:0] select_word =
		32'({relay_output_selector, 3'h0, transistor_output_selector});
	wire logic [31:0] status_word =
		32'({relay_contact_status_out, open_collector_status_out, 6'h00, cond});

	wire logic [31:0] wr_old =
		(wa == `FDO_LEVEL_OFS)     ? 32'(detect_level_setting) :
		(wa == `FDO_BANDWIDTH_OFS) ? 32'(detect_bandwidth_setting) :
		(wa == `FDO_MAXFREQ_OFS)   ? 32'(maximum_frequency_limit) :
		(wa == `FDO_SELECT_OFS)    ? select_word :
		(wa == `FDO_MASK_OFS)      ? 32'(fault_indication_mask) : 32'h0000_0000;
	wire logic [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	wire logic [31:0] merged    = (w_data & strb_mask) | (wr_old & ~strb_mask);

	wire freq_t new_freq   = merged[15:0];
	wire sel_t  new_oc_sel = merged[`FDO_SEL_OC_LSB +: 5];
	wire sel_t  new_rl_sel = merged[`FDO_SEL_RELAY_LSB +: 5];
	wire logic  freq_hi    = (merged[31:16] != 16'h0000) || (new_freq > `FDO_FREQ_LIMIT);
	// a setting above the maximum frequency is refused and keeps its old value
	wire logic  set_bad    = freq_hi || (new_freq > maximum_frequency_limit);
	wire logic  sel_bad    = (new_oc_sel > `FDO_SEL_MAX) || (new_rl_sel > `FDO_SEL_MAX);

	wire logic hit_lvl  = (wa == `FDO_LEVEL_OFS);
	wire logic hit_bw   = (wa == `FDO_BANDWIDTH_OFS);
	wire logic hit_max  = (wa == `FDO_MAXFREQ_OFS);
	wire logic hit_sel  = (wa == `FDO_SELECT_OFS);
	wire logic hit_mask = (wa == `FDO_MASK_OFS);
	wire logic hit_stat = (wa == `FDO_STATUS_OFS);
	wire logic wr_mapped = hit_lvl | hit_bw | hit_max | hit_sel | hit_mask | hit_stat;
	wire logic wr_refuse = ((hit_lvl | hit_bw) & set_bad) | (hit_max & freq_hi) | (hit_sel & sel_bad);
	wire logic [1:0] wr_resp = !wr_mapped ? `FDO_RESP_DECERR :
	                           wr_refuse  ? `FDO_RESP_SLVERR : `FDO_RESP_OKAY;
	wire logic wr_ok = wr_fire & wr_mapped & ~wr_refuse;

	// ----------------------------------------------------------------
	// setting registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			detect_level_setting       <= `FDO_LEVEL_RESET;
			detect_bandwidth_setting   <= `FDO_BW_RESET;
			maximum_frequency_limit    <= `FDO_MAXFREQ_RESET;
			transistor_output_selector <= `FDO_SEL_OC_RESET;
			relay_output_selector      <= `FDO_SEL_RLY_RESET;
			fault_indication_mask      <= `FDO_MASK_RESET;
		end else if (wr_ok) begin
			if (hit_lvl)
				detect_level_setting <= new_freq;
			if (hit_bw)
				detect_bandwidth_setting <= new_freq;
			if (hit_max)
				maximum_frequency_limit <= new_freq;
			if (hit_sel) begin
				transistor_output_selector <= new_oc_sel;
				relay_output_selector      <= new_rl_sel;
			end
			if (hit_mask)
				fault_indication_mask <= merged[2:0];
		end
	end

	// ----------------------------------------------------------------
	// write response
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `FDO_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_resp;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	assign s_axi_arready = ~s_axi_rvalid;

	wire logic rd_mapped = (ra == `FDO_LEVEL_OFS) || (ra == `FDO_BANDWIDTH_OFS) ||
	                       (ra == `FDO_MAXFREQ_OFS) || (ra == `FDO_SELECT_OFS) ||
	                       (ra == `FDO_MASK_OFS) || (ra == `FDO_STATUS_OFS);
	wire logic [31:0] rd_word =
		(ra == `FDO_LEVEL_OFS)     ? 32'(detect_level_setting) :
		(ra == `FDO_BANDWIDTH_OFS) ? 32'(detect_bandwidth_setting) :
		(ra == `FDO_MAXFREQ_OFS)   ? 32'(maximum_frequency_limit) :
		(ra == `FDO_SELECT_OFS)    ? select_word :
		(ra == `FDO_MASK_OFS)      ? 32'(fault_indication_mask) :
		(ra == `FDO_STATUS_OFS)    ? status_word : 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `FDO_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_mapped ? `FDO_RESP_OKAY : `FDO_RESP_DECERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	wire freq_t chk_half = detect_bandwidth_setting >> 1;
	wire freq_t chk_cmd_diff = (cmd_freq > run_freq) ? cmd_freq - run_freq : run_freq - cmd_freq;

	fdt_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(transistor_output_selector == 5'h00 && chk_cmd_diff <= chk_half)
		|=> open_collector_status_out)
		else $error("code 0 missed a command match");

	level_cmd_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(transistor_output_selector == 5'h01 && cmd_freq != detect_level_setting)
		|=> !open_collector_status_out)
		else $error("code 1 active without level match");

	level_band_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(transistor_output_selector == 5'h02 &&
		 run_freq <= detect_level_setting + chk_half &&
		 run_freq + chk_half >= detect_level_setting && detect_level_setting < 16'h8000)
		|=> open_collector_status_out)
		else $error("code 2 missed level band");

	accel_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(transistor_output_selector == 5'h03 && drive_status.accelerating &&
		 run_freq >= detect_level_setting) |=> open_collector_status_out)
		else $error("code 3 missed level crossing");

	accel_inv_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(relay_output_selector == 5'h04 && drive_status.accelerating &&
		 run_freq < detect_level_setting) |=> relay_contact_status_out)
		else $error("code 4 not inverse of code 3");

	level_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(detect_level_setting <= `FDO_FREQ_LIMIT) && (detect_bandwidth_setting <= `FDO_FREQ_LIMIT))
		else $error("setting above 400 Hz accepted");

	ov_trip_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(relay_output_selector == 5'h08) |=>
		(relay_contact_status_out == $past(drive_status.overvoltage_trip)))
		else $error("code 8 does not follow over-voltage trip");

	run_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(transistor_output_selector == 5'h0C) |=>
		(open_collector_status_out == $past(run_and_output)))
		else $error("code 12 does not follow run and output");

	fault_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(relay_output_selector == 5'h11 && fault_indication_mask == 3'h2 &&
		 drive_status.undervoltage_trip && !drive_status.other_trip)
		|=> !relay_contact_status_out)
		else $error("mask 2 indicated an under-voltage trip");

endmodule

`default_nettype wire

// >>> status_watch.sv
/*
 * Far-side model: the external control sequence that samples the two
 * status outputs of the drive once per clock.
 * Assumes the outputs are levels synchronous to aclk.
 */
`default_nettype none

module status_watch (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// drive outputs
	input  wire logic oc_in,
	input  wire logic relay_in,
	// what the sequence saw
	output logic      oc_seen,
	output logic      relay_seen
);
	timeunit 1ns;
	timeprecision 1ps;

	// the sequence only ever reads levels, it has no handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			oc_seen    <= 1'b0;
			relay_seen <= 1'b0;
		end else begin
			oc_seen    <= oc_in;
			relay_seen <= relay_in;
		end
	end
endmodule

`default_nettype wire

// >>> test_freq_detect_output_select.sv
/*
 * Self-checking bench: register access over AXI4-Lite, random drive
 * state, an integer model of every condition code compared each round.
 * Assumes the design and status_watch are compiled before this file.
 */
`include "fdo_regs.svh"
`default_nettype none

module test_freq_detect_output_select
	import fdo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic          aclk = 0, aresetn = 0;
	logic [7:0]    awaddr = 0, araddr = 0;
	logic [31:0]   wdata = 0, rdata;
	logic          awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
	logic          arvalid = 0, arready, rvalid, rready = 0;
	logic [3:0]    wstrb = 0;
	logic [1:0]    bresp, rresp;
	freq_t         cmd_freq = 0, run_freq = 0;
	drive_status_s ds = '0;
	logic          oc_out, relay_out, oc_seen, relay_seen;
	logic [31:0]   seed = 32'hf941_24b3;
	logic [31:0]   rd;
	logic [1:0]    rs;
	int            fails = 0, n_tests = 0, cyc = 0;
	int            lvl = 3000, bw = 1000, msk = 2, hyst = 0, s_oc, s_rl;
	logic [17:0]   exp_c;

	always #5 aclk = ~aclk;

	freq_detect_output_select #(.ADDR_W(8)) u_freq_detect_output_select (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmd_freq(cmd_freq),
		.run_freq(run_freq), .drive_status(ds),
		.open_collector_status_out(oc_out), .relay_contact_status_out(relay_out));

	status_watch u_status_watch (.aclk(aclk), .aresetn(aresetn), .oc_in(oc_out),
		.relay_in(relay_out), .oc_seen(oc_seen), .relay_seen(relay_seen));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw_d, w_d;
		aw_d = 0;
		w_d = 0;
		@(posedge aclk);
		awaddr <= a; awvalid <= 1; wdata <= d; wstrb <= 4'hf; wvalid <= 1; bready <= 1;
		while (!(aw_d && w_d)) begin
			@(posedge aclk);
			if (!aw_d && awready === 1'b1) begin aw_d = 1; awvalid <= 0; end
			if (!w_d && wready === 1'b1) begin w_d = 1; wvalid <= 0; end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		r = bresp;
		bready <= 0;
	endtask

	task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 0;
	endtask

	// integer model of the eighteen condition codes
	function automatic logic [17:0] model(int c, int f);
		logic [17:0] m;
		int h;
		h = bw / 2;
		m = '0;
		if (ds.accelerating) hyst = (f >= lvl);
		else if (ds.decelerating) hyst = (f > lvl - h);
		m[0]  = (c - f <= h) && (f - c <= h);
		m[1]  = (c == lvl) && m[0];
		m[2]  = (lvl - f <= h) && (f - lvl <= h);
		m[3]  = hyst[0];
		m[4]  = !hyst[0];
		m[5]  = ds.overload_warn;
		m[6]  = ds.inverter_overload;
		m[7]  = ds.motor_stall;
		m[8]  = ds.overvoltage_trip;
		m[9]  = ds.undervoltage_trip;
		m[10] = ds.heatsink_overtemp_trip;
		m[11] = ds.command_lost;
		m[12] = ds.run_command && ds.output_active;
		m[13] = ds.stopped;
		m[14] = ds.constant_speed;
		m[15] = ds.speed_searching;
		m[16] = ds.waiting_run_command;
		m[17] = (msk[0] && ds.undervoltage_trip) || (msk[1] && ds.other_trip)
			|| (msk[2] && ds.restart_retrying);
		return m;
	endfunction

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// hang guard, about thirteen times the expected run
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int f, c;
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		rdr(`FDO_LEVEL_OFS, rd, rs);     chk("level reset", 32'h0000_0bb8, rd);
		rdr(`FDO_BANDWIDTH_OFS, rd, rs); chk("bw reset", 32'h0000_03e8, rd);
		rdr(`FDO_SELECT_OFS, rd, rs);    chk("sel reset", 32'h0000_110c, rd);
		rdr(`FDO_MASK_OFS, rd, rs);      chk("mask reset", 32'h0000_0002, rd);
		// refused settings leave the stored values alone
		wr(`FDO_LEVEL_OFS, 32'h0000_1771, rs);     chk("level above max", 2'h2, rs);
		wr(`FDO_BANDWIDTH_OFS, 32'h0000_9c41, rs); chk("bw above limit", 2'h2, rs);
		wr(`FDO_MAXFREQ_OFS, 32'h0000_9c41, rs);   chk("max above limit", 2'h2, rs);
		wr(`FDO_SELECT_OFS, 32'h0000_1200, rs);    chk("sel 18", 2'h2, rs);
		rdr(`FDO_LEVEL_OFS, rd, rs);  chk("level kept", 32'h0000_0bb8, rd);
		rdr(`FDO_SELECT_OFS, rd, rs); chk("sel kept", 32'h0000_110c, rd);
		wr(`FDO_STATUS_OFS, 32'hffff_ffff, rs);    chk("status write", 2'h0, rs);
		rdr(8'h40, rd, rs);                        chk("unmapped", 2'h3, rs);
		// under-voltage alone stays dark with mask 2, another trip lights it
		ds.undervoltage_trip <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("uv masked", 1'b0, relay_out);
		ds.other_trip <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("other trip", 1'b1, relay_out);
		for (int i = 0; i < 120; i++) begin
			if (i % 4 == 0) begin
				lvl = xs() % 6001;
				bw = xs() % 6001;
				wr(`FDO_LEVEL_OFS, lvl, rs);     chk("level wr", 2'h0, rs);
				wr(`FDO_BANDWIDTH_OFS, bw, rs);  chk("bw wr", 2'h0, rs);
				// a ramp still under way re-evaluates against the new settings
				exp_c = model(cmd_freq, run_freq);
			end
			s_oc = i % 18;
			s_rl = xs() % 18;
			msk = xs() % 8;
			wr(`FDO_SELECT_OFS, (s_rl << 8) | s_oc, rs); chk("sel wr", 2'h0, rs);
			wr(`FDO_MASK_OFS, msk, rs);                  chk("mask wr", 2'h0, rs);
			f = lvl + int'(xs() % 1201) - 600;
			if (f < 0) f = 0;
			rd = xs();
			c = rd[0] ? lvl : f + int'(xs() % 801) - 400;
			if (c < 0) c = 0;
			@(posedge aclk);
			cmd_freq <= 16'(c);
			run_freq <= 16'(f);
			ds <= 17'(xs());
			@(posedge aclk);
			if (ds.accelerating) ds.decelerating <= 0;
			repeat (3) @(posedge aclk);
			exp_c = model(c, f);
			rdr(`FDO_STATUS_OFS, rd, rs);
			chk("conditions", exp_c, rd[17:0]);
			chk("oc out", exp_c[s_oc], oc_out);
			chk("relay out", exp_c[s_rl], relay_out);
			chk("oc seen", exp_c[s_oc], oc_seen);
			chk("relay seen", exp_c[s_rl], relay_seen);
			chk("stat oc", exp_c[s_oc], rd[`FDO_STAT_OC_BIT]);
			chk("stat relay", exp_c[s_rl], rd[`FDO_STAT_RELAY_BIT]);
		end
		end_sim();
	end
endmodule

`default_nettype wire
